// ===== common/ucd_pkg.sv
/*
  constants for the unit command decoder: register offsets, command field
  layout, command codes, unit state encodings.
  assumes a 32-bit register port with one-cycle read latency.
*/
package ucd_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_COMMAND = 4'h0;
  localparam logic [3:0] OFF_GEN_PTR = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_CU_BASE = 4'hc;
  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int CUC_LSB = 20;
  localparam int RUC_LSB = 16;
  localparam int RSV_BIT = 19;
  localparam int HDS_BITS = 14;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // command unit codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CU_NOP = 4'h0;
  localparam logic [3:0] CU_START = 4'h1;
  localparam logic [3:0] CU_RESUME = 4'h2;
  localparam logic [3:0] CU_LOAD_DUMP = 4'h4;
  localparam logic [3:0] CU_DUMP = 4'h5;
  localparam logic [3:0] CU_LOAD_BASE = 4'h6;
  localparam logic [3:0] CU_DUMP_CLEAR = 4'h7;
  localparam logic [3:0] CU_STATIC_RESUME = 4'ha;
  // ----------------------------------------------------------------
  // receive unit codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RU_NOP = 3'h0;
  localparam logic [2:0] RU_START = 3'h1;
  localparam logic [2:0] RU_RESUME = 3'h2;
  localparam logic [2:0] RU_REDIRECT = 3'h3;
  localparam logic [2:0] RU_ABORT = 3'h4;
  localparam logic [2:0] RU_LOAD_HDS = 3'h5;
  localparam logic [2:0] RU_LOAD_BASE = 3'h6;
  // ----------------------------------------------------------------
  // reported states
  // ----------------------------------------------------------------
  localparam logic [1:0] CUS_IDLE = 2'h0;
  localparam logic [1:0] CUS_SUSP = 2'h1;
  localparam logic [1:0] CUS_LPQ = 2'h2;
  localparam logic [1:0] CUS_HPQ = 2'h3;
  localparam logic [3:0] RUS_IDLE = 4'h0;
  localparam logic [3:0] RUS_SUSP = 4'h1;
  localparam logic [3:0] RUS_READY = 4'h4;
  localparam logic [3:0] STAT_RESET = 4'h0;
endpackage

// ===== design/dump_sequencer.sv
/*
  statistics dump sequencer: writes the counters out, then optionally
  clears them. assumes the dma side acknowledges each request with done.
*/
module dump_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic clear_after,
  input wire logic dma_done,
  output logic dma_req,
  output logic counters_clear,
  output logic busy
);
  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_CLEAR} seq_t;
  seq_t state_q, state_d;
  logic clear_after_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (start) state_d = S_WRITE;
      S_WRITE: if (dma_done) state_d = clear_after_q ? S_CLEAR : S_IDLE;
      S_CLEAR: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= S_IDLE;
      clear_after_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start && state_q == S_IDLE) clear_after_q <= clear_after;
    end
  end

  // clear only after the write has finished
  assign counters_clear = (state_q == S_CLEAR);
  assign dma_req = (state_q == S_WRITE);
  assign busy = (state_q != S_IDLE);
endmodule // dump_sequencer

// ===== design/unit_command_decoder.sv
/*
  unit command decoder: accepts command unit and receive unit commands
  from the command word, updates unit states, base registers and dump
  address, and drives start pulses to the dma engines.
  assumes the dma engines report progress through the *_done inputs.
*/
// Added by the designer: the placing of the registers and strobed register access.
module unit_command_decoder (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic cu_block_done,
  input wire logic cu_list_end,
  input wire logic cu_suspend,
  input wire logic rx_suspend,
  input wire logic dump_done,
  output logic cu_fetch,
  output logic [31:0] cu_fetch_addr,
  output logic ru_fetch,
  output logic [31:0] ru_fetch_addr,
  output logic ru_redirect,
  output logic ru_enable,
  output logic header_mode,
  output logic [13:0] header_data_size,
  output logic [31:0] dump_addr,
  output logic dump_req,
  output logic counters_clear
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] gen_ptr_q;
  logic [31:0] cu_base_q;
  logic [31:0] ru_base_q;
  logic [31:0] dump_addr_q;
  logic [3:0] cuc_q;
  logic [2:0] ruc_q;
  logic [1:0] cus_q;
  logic [3:0] rus_q;
  logic hds_mode_q;
  logic [13:0] hds_q;
  logic cu_fetch_q, ru_fetch_q, redirect_q;
  logic [31:0] cu_fetch_addr_q, ru_fetch_addr_q;
  logic [31:0] rdata_q;
  logic dump_busy;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire cmd_wr = wr && (addr == ucd_pkg::OFF_COMMAND);
  wire ptr_wr = wr && (addr == ucd_pkg::OFF_GEN_PTR);
  wire cu_pend = (cuc_q != ucd_pkg::CU_NOP);
  wire ru_pend = (ruc_q != ucd_pkg::RU_NOP);
  // dump commands wait while a dump is still running
  wire cu_accept = cu_pend && !(dump_busy && (cuc_q == ucd_pkg::CU_DUMP ||
                   cuc_q == ucd_pkg::CU_DUMP_CLEAR));
  wire cu_idle = (cus_q == ucd_pkg::CUS_IDLE);
  wire do_cu_start = cu_accept && cuc_q == ucd_pkg::CU_START;
  wire do_cu_resume = cu_accept && !cu_idle &&
                      (cuc_q == ucd_pkg::CU_RESUME ||
                       cuc_q == ucd_pkg::CU_STATIC_RESUME);
  wire do_dump = cu_accept && (cuc_q == ucd_pkg::CU_DUMP ||
                 cuc_q == ucd_pkg::CU_DUMP_CLEAR);
  wire do_ru_start = ru_pend && ruc_q == ucd_pkg::RU_START;
  wire do_ru_resume = ru_pend && ruc_q == ucd_pkg::RU_RESUME &&
                      rus_q == ucd_pkg::RUS_SUSP;
  wire do_ru_abort = ru_pend && ruc_q == ucd_pkg::RU_ABORT;
  wire do_redirect = ru_pend && ruc_q == ucd_pkg::RU_REDIRECT;

  function automatic logic [31:0] add_base(input logic [31:0] b, input logic [31:0] p);
    add_base = b + p;
  endfunction

  // ------------------------------------------------------------
  // command byte: set by software, cleared on acceptance
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cuc_q <= ucd_pkg::CU_NOP;
      ruc_q <= ucd_pkg::RU_NOP;
    end else if (cmd_wr) begin
      cuc_q <= wdata[ucd_pkg::CUC_LSB +: 4];
      ruc_q <= wdata[ucd_pkg::RUC_LSB +: 3];
    end else begin
      if (cu_accept) cuc_q <= ucd_pkg::CU_NOP;
      if (ru_pend) ruc_q <= ucd_pkg::RU_NOP;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) gen_ptr_q <= ucd_pkg::WORD_RESET;
    else if (ptr_wr) gen_ptr_q <= wdata;
  end

  // ------------------------------------------------------------
  // command unit
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cus_q <= ucd_pkg::CUS_IDLE;
      cu_base_q <= ucd_pkg::WORD_RESET;
      dump_addr_q <= ucd_pkg::WORD_RESET;
      cu_fetch_q <= 1'b0;
      cu_fetch_addr_q <= ucd_pkg::WORD_RESET;
    end else begin
      cu_fetch_q <= do_cu_start || do_cu_resume;
      if (do_cu_start) begin
        cus_q <= ucd_pkg::CUS_LPQ;
        cu_fetch_addr_q <= add_base(cu_base_q, gen_ptr_q);
      end else if (do_cu_resume) begin
        cus_q <= ucd_pkg::CUS_LPQ;
      end else if (cus_q == ucd_pkg::CUS_LPQ && cu_list_end) begin
        cus_q <= ucd_pkg::CUS_IDLE;
      end else if (cus_q == ucd_pkg::CUS_LPQ && cu_suspend) begin
        cus_q <= ucd_pkg::CUS_SUSP;
      end
      if (cu_block_done && cus_q == ucd_pkg::CUS_LPQ && !do_cu_start)
        cu_fetch_addr_q <= cu_fetch_addr_q; // next address owned by dma
      // no-op and unlisted codes fall through untouched
      if (cu_accept && cuc_q == ucd_pkg::CU_LOAD_DUMP) dump_addr_q <= gen_ptr_q;
      if (cu_accept && cuc_q == ucd_pkg::CU_LOAD_BASE) cu_base_q <= gen_ptr_q;
    end
  end

  dump_sequencer dump_seq (
    .clk(clk),
    .reset(reset),
    .start(do_dump),
    .clear_after(cuc_q == ucd_pkg::CU_DUMP_CLEAR),
    .dma_done(dump_done),
    .dma_req(dump_req),
    .counters_clear(counters_clear),
    .busy(dump_busy)
  );

  // ------------------------------------------------------------
  // receive unit
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rus_q <= ucd_pkg::RUS_IDLE;
      ru_base_q <= ucd_pkg::WORD_RESET;
      hds_mode_q <= 1'b0;
      hds_q <= '0;
      ru_fetch_q <= 1'b0;
      redirect_q <= 1'b0;
      ru_fetch_addr_q <= ucd_pkg::WORD_RESET;
    end else begin
      ru_fetch_q <= do_ru_start || do_ru_resume;
      redirect_q <= do_redirect;
      if (do_ru_abort) begin
        rus_q <= ucd_pkg::RUS_IDLE;
      end else if (do_ru_start || do_ru_resume) begin
        rus_q <= ucd_pkg::RUS_READY;
      end else if (rus_q == ucd_pkg::RUS_READY && rx_suspend) begin
        rus_q <= ucd_pkg::RUS_SUSP;
      end
      if (do_ru_start) ru_fetch_addr_q <= add_base(ru_base_q, gen_ptr_q);
      if (do_redirect) ru_fetch_addr_q <= add_base(ru_base_q, gen_ptr_q);
      if (ru_pend && ruc_q == ucd_pkg::RU_LOAD_HDS) begin
        hds_mode_q <= 1'b1;
        hds_q <= gen_ptr_q[ucd_pkg::HDS_BITS-1:0];
      end
      if (ru_pend && ruc_q == ucd_pkg::RU_LOAD_BASE) ru_base_q <= gen_ptr_q;
      // no-op and unlisted codes fall through untouched
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  wire [31:0] cmd_view = {8'h00, cuc_q, 1'b0, ruc_q, 16'h0000};
  wire [31:0] stat_view = {24'h000000, cus_q, rus_q, 2'b00};
  wire [31:0] rd_mux = (addr == ucd_pkg::OFF_COMMAND) ? cmd_view :
                       (addr == ucd_pkg::OFF_GEN_PTR) ? gen_ptr_q :
                       (addr == ucd_pkg::OFF_STATUS) ? stat_view :
                       (addr == ucd_pkg::OFF_CU_BASE) ? cu_base_q : 32'h0000_0000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) rdata_q <= ucd_pkg::WORD_RESET;
    else if (rd) rdata_q <= rd_mux;
    else rdata_q <= ucd_pkg::WORD_RESET;
  end

  assign rdata = rdata_q;
  assign cu_fetch = cu_fetch_q;
  assign cu_fetch_addr = cu_fetch_addr_q;
  assign ru_fetch = ru_fetch_q;
  assign ru_fetch_addr = ru_fetch_addr_q;
  assign ru_redirect = redirect_q;
  assign ru_enable = (rus_q == ucd_pkg::RUS_READY);
  assign header_mode = hds_mode_q;
  assign header_data_size = hds_q;
  assign dump_addr = dump_addr_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence cu_start_seen;
    do_cu_start;
  endsequence

  cu_start_fetch_a: assert property (@(posedge clk) disable iff (reset)
    cu_start_seen |=> cu_fetch && cus_q == ucd_pkg::CUS_LPQ)
    else $error("cu start did not fetch");
  cu_base_add_a: assert property (@(posedge clk) disable iff (reset)
    do_cu_start |=> cu_fetch_addr == $past(cu_base_q) + $past(gen_ptr_q))
    else $error("cu fetch address not base plus pointer");
  cu_idle_resume_a: assert property (@(posedge clk) disable iff (reset)
    (cu_pend && cuc_q == ucd_pkg::CU_RESUME && cu_idle && !cmd_wr) |=> !cu_fetch)
    else $error("resume acted while idle");
  cu_nop_a: assert property (@(posedge clk) disable iff (reset)
    (cuc_q == ucd_pkg::CU_NOP && !cu_list_end && !cu_suspend) |=> $stable(cus_q))
    else $error("cu state changed on no-op");
  dump_load_a: assert property (@(posedge clk) disable iff (reset)
    (cu_accept && cuc_q == ucd_pkg::CU_LOAD_DUMP) |=> dump_addr == $past(gen_ptr_q))
    else $error("dump address not loaded");
  dump_order_a: assert property (@(posedge clk) disable iff (reset)
    counters_clear |-> $past(dump_req) && $past(dump_done))
    else $error("counters cleared before dump finished");
  cmd_clear_a: assert property (@(posedge clk) disable iff (reset)
    (ru_pend && !cmd_wr) |=> ruc_q == ucd_pkg::RU_NOP)
    else $error("ru command byte not cleared");
  ru_abort_a: assert property (@(posedge clk) disable iff (reset)
    do_ru_abort |=> !ru_enable)
    else $error("abort did not stop receive");
  hds_keep_a: assert property (@(posedge clk) disable iff (reset)
    header_mode |=> header_mode)
    else $error("header mode dropped before reset");
  ru_resume_a: assert property (@(posedge clk) disable iff (reset)
    (ru_pend && ruc_q == ucd_pkg::RU_RESUME && rus_q != ucd_pkg::RUS_SUSP) |=> !ru_fetch)
    else $error("ru resume acted when not suspended");
endmodule // unit_command_decoder

// ===== verif/unit_command_decoder_bench.sv
/*
  self-checking bench for unit_command_decoder: register port tasks,
  dma feedback pulses, command sequences with expected outputs.
  assumes a 100 MHz clock, async high reset and the note's timing.
*/
module unit_command_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, wr, rd;
  logic [3:0] addr;
  logic [4:0] fb;
  logic [31:0] wdata, rdata, cu_fetch_addr, ru_fetch_addr, dump_addr, rv;
  logic cu_fetch, ru_fetch, ru_redirect, ru_enable, header_mode, dump_req, counters_clear;
  logic [13:0] header_data_size;
  logic [31:0] flags;
  int error_cnt, comparisons, cycles;
  // ----------------------------------------------------------------
  // design
  // ----------------------------------------------------------------
  unit_command_decoder u_unit_command_decoder (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cu_block_done(fb[0]),
    .cu_list_end(fb[1]), .cu_suspend(fb[2]), .rx_suspend(fb[3]), .dump_done(fb[4]),
    .cu_fetch(cu_fetch), .cu_fetch_addr(cu_fetch_addr), .ru_fetch(ru_fetch),
    .ru_fetch_addr(ru_fetch_addr), .ru_redirect(ru_redirect), .ru_enable(ru_enable),
    .header_mode(header_mode), .header_data_size(header_data_size),
    .dump_addr(dump_addr), .dump_req(dump_req), .counters_clear(counters_clear));
  // one vector so a single compare pins every strobe and level at once
  assign flags = {25'h0, cu_fetch, ru_fetch, ru_redirect, ru_enable, header_mode, dump_req,
    counters_clear};
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  // leaves time in the cycle where the command's effect is first visible
  task automatic cmd(input logic [31:0] gp, input logic [3:0] cuc, input logic [2:0] rx_unit_command_field);
    reg_wr(ucd_pkg::OFF_GEN_PTR, gp);
    reg_wr(ucd_pkg::OFF_COMMAND, {8'h00, cuc, 1'b0, rx_unit_command_field, 16'h0000});
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int idx);
    @(posedge clk);
    fb[idx] <= 1'b1;
    @(posedge clk);
    fb <= 5'h00;
  endtask
  task automatic status(input logic [1:0] cus, input logic [3:0] rus);
    reg_rd(ucd_pkg::OFF_STATUS);
    check("cu state", {30'h0, rv[7:6]}, {30'h0, cus});
    check("ru state", {28'h0, rv[5:2]}, {28'h0, rus});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    fb = 5'h00;
    cycles = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("flags", flags, 32'h0);
    status(ucd_pkg::CUS_IDLE, ucd_pkg::RUS_IDLE);
    cmd(32'h0, ucd_pkg::CU_RESUME, ucd_pkg::RU_NOP);
    check("resume idle", flags, 32'h0);
    cmd(32'h0, ucd_pkg::CU_STATIC_RESUME, ucd_pkg::RU_NOP);
    check("static idle", flags, 32'h0);
    status(ucd_pkg::CUS_IDLE, ucd_pkg::RUS_IDLE);
    cmd(32'h0001_0000, ucd_pkg::CU_LOAD_BASE, ucd_pkg::RU_NOP);
    reg_rd(ucd_pkg::OFF_CU_BASE);
    check("cu base", rv, 32'h0001_0000);
    cmd(32'h0000_0100, ucd_pkg::CU_START, ucd_pkg::RU_NOP);
    check("start", flags, 32'h40);
    check("fetch addr", cu_fetch_addr, 32'h0001_0100);
    status(ucd_pkg::CUS_LPQ, ucd_pkg::RUS_IDLE);
    reg_rd(ucd_pkg::OFF_COMMAND);
    check("cmd byte", {24'h0, rv[23:16]}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      cmd(32'h0, (i == 0) ? ucd_pkg::CU_NOP : ((i == 1) ? 4'h8 : 4'hf), ucd_pkg::RU_NOP);
      check("no-op", flags, 32'h0);
      status(ucd_pkg::CUS_LPQ, ucd_pkg::RUS_IDLE);
    end
    for (int i = 0; i < 2; i++) begin
      pulse(2);
      status(ucd_pkg::CUS_SUSP, ucd_pkg::RUS_IDLE);
      cmd(32'h0, (i == 0) ? ucd_pkg::CU_RESUME : ucd_pkg::CU_STATIC_RESUME, ucd_pkg::RU_NOP);
      check("resume", flags, 32'h40);
      status(ucd_pkg::CUS_LPQ, ucd_pkg::RUS_IDLE);
    end
    pulse(1);
    status(ucd_pkg::CUS_IDLE, ucd_pkg::RUS_IDLE);
    $display("command unit test done");
    cmd(32'h0003_0000, ucd_pkg::CU_LOAD_DUMP, ucd_pkg::RU_NOP);
    check("dump addr", dump_addr, 32'h0003_0000);
    for (int i = 0; i < 2; i++) begin
      cmd(32'h0, (i == 0) ? ucd_pkg::CU_DUMP : ucd_pkg::CU_DUMP_CLEAR, ucd_pkg::RU_NOP);
      check("dump req", flags, 32'h02);
      @(posedge clk);
      fb[4] <= 1'b1;
      @(posedge clk);
      fb[4] <= 1'b0;
      #1;
      check("clear after", flags, (i == 0) ? 32'h00 : 32'h01);
    end
    $display("dump test done");
    cmd(32'h0002_0000, ucd_pkg::CU_NOP, ucd_pkg::RU_LOAD_BASE);
    cmd(32'h0000_0040, ucd_pkg::CU_NOP, ucd_pkg::RU_START);
    check("ru start", flags, 32'h28);
    check("ru addr", ru_fetch_addr, 32'h0002_0040);
    status(ucd_pkg::CUS_IDLE, ucd_pkg::RUS_READY);
    cmd(32'h0, ucd_pkg::CU_NOP, ucd_pkg::RU_RESUME);
    check("resume ready", flags, 32'h08);
    pulse(3);
    status(ucd_pkg::CUS_IDLE, ucd_pkg::RUS_SUSP);
    cmd(32'h0, ucd_pkg::CU_NOP, ucd_pkg::RU_RESUME);
    check("resume susp", flags, 32'h28);
    for (int i = 0; i < 2; i++) begin
      cmd(32'h0, ucd_pkg::CU_NOP, (i == 0) ? ucd_pkg::RU_NOP : 3'h7);
      check("ru no-op", flags, 32'h08);
      status(ucd_pkg::CUS_IDLE, ucd_pkg::RUS_READY);
    end
    cmd(32'h0000_0080, ucd_pkg::CU_NOP, ucd_pkg::RU_REDIRECT);
    check("redirect", {31'h0, ru_redirect}, 32'h1);
    check("redir addr", ru_fetch_addr, 32'h0002_0080);
    cmd(32'h0, ucd_pkg::CU_NOP, ucd_pkg::RU_ABORT);
    check("abort", {31'h0, ru_enable}, 32'h0);
    status(ucd_pkg::CUS_IDLE, ucd_pkg::RUS_IDLE);
    cmd(32'h0000_1ffe, ucd_pkg::CU_NOP, ucd_pkg::RU_LOAD_HDS);
    check("hds", {18'h0, header_data_size}, 32'h1ffe);
    cmd(32'h0000_0040, ucd_pkg::CU_NOP, ucd_pkg::RU_START);
    check("header mode", {31'h0, header_mode}, 32'h1);
    reg_wr(ucd_pkg::OFF_COMMAND, 32'h0000_0000);
    reg_rd(ucd_pkg::OFF_COMMAND);
    check("reserved bit", {31'h0, rv[19]}, 32'h0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("mode after reset", flags, 32'h0);
    $display("receive unit test done");
    conclude();
  end
endmodule // unit_command_decoder_bench
